// ===== sfci_defs.svh
// Summary of operation
// - opcodes, addresses and data move most significant bit first, both directions.
// - input bits are captured on rising serial clock edges after select falls.
// - read data is driven out; host may end the read after any bit.
// - write and erase run only if select rises on a whole byte boundary.
// - memory commands are refused while a write or erase cycle runs.
// - opcode 06 with nothing else sets the write enable latch, status bit 1.
// - opcode 04 with nothing else clears the write enable latch.
// - latch clears at power-up and when any write or erase cycle completes, unless opcode 06 sets it in the same cycle.
// - opcode 05 returns the status byte, repeated while select stays low.
// - read 03 takes three address bytes; fast read 0B adds one dummy byte.
// - write bytes 02 takes address then data; only the last 256 are kept.
// - with the latch clear, every write and erase command is refused.
// - write in progress reads 1 during a cycle and 0 otherwise.
// - bulk erase C7 runs only when every protect bit is 0.
// - write bytes and sector erase D8 are blocked in the protected region.
// - opcode AB takes three dummy bytes then repeats the id, low densities only.
// - opcode 9F takes two dummy bytes then repeats the id, high density only.
// - four sectors: 00 none, 01 sector 3, 10 sectors 2-3, 11 all.
// - eight sectors: 000 none, 001 s7, 010 s6-7, 011 s4-7, 1xx all.
// - write status 01 with one data byte changes only the protect bits.
// - write status runs only if select rises right after its eighth data bit.
// - write in progress sits in status bit 0.
`ifndef SFCI_DEFS_SVH
`define SFCI_DEFS_SVH

// ==========================================================
// opcodes
`define SFCI_OP_WREN   8'h06
`define SFCI_OP_WRDI   8'h04
`define SFCI_OP_RDSR   8'h05
`define SFCI_OP_READ   8'h03
`define SFCI_OP_FAST   8'h0B
`define SFCI_OP_WSTAT  8'h01
`define SFCI_OP_PROG   8'h02
`define SFCI_OP_BULK   8'hC7
`define SFCI_OP_SECT   8'hD8
`define SFCI_OP_SID    8'hAB
`define SFCI_OP_RDID   8'h9F

// ==========================================================
// framing counts
`define SFCI_ADDR_LEFT   2'h2
`define SFCI_SID_LEFT    2'h2
`define SFCI_RDID_LEFT   2'h1
`define SFCI_WSTAT_BYTES 4'h2
`define SFCI_SECT_BYTES  4'h4
`define SFCI_OPC_BYTES   4'h1
`define SFCI_BYTE_MAX    4'hF
`define SFCI_LAST_BIT    3'h7
`define SFCI_PAGE_BYTES  9'h100

// ==========================================================
// status layout and sector fields
`define SFCI_WIP_BIT   0
`define SFCI_WEL_BIT   1
`define SFCI_BP_LSB    2
`define SFCI_SEC4_LSB  15
`define SFCI_SEC8_LSB  16
`define SFCI_BP_RESET  3'h0

`endif

// ===== sfci_pkg.sv
package sfci_pkg;

	typedef enum logic [5:0] {
		ST_OPCODE   = 6'b00_0001,
		ST_ADDR     = 6'b00_0010,
		ST_DUMMY    = 6'b00_0100,
		ST_DATA_IN  = 6'b00_1000,
		ST_DATA_OUT = 6'b01_0000,
		ST_IGNORE   = 6'b10_0000
	} sfci_state_e;

	typedef enum logic [1:0] {
		OP_PROG  = 2'h0,
		OP_SECT  = 2'h1,
		OP_BULK  = 2'h2,
		OP_WSTAT = 2'h3
	} sfci_op_e;

endpackage : sfci_pkg

// ===== sfci_page_buf.sv
`timescale 1ns/100ps
module sfci_page_buf (
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data
);
	logic [7:0] mem [0:255];

	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : sfci_page_buf

// ===== sfci_top.sv
`timescale 1ns/100ps
`include "sfci_defs.svh"
module sfci_top import sfci_pkg::*; #(
	// identity values are arbitrary
	parameter logic [7:0] SILICON_ID = 8'h5A,
	parameter logic [7:0] DEVICE_ID  = 8'hA5
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        chip_select_n,
	input  wire logic        serial_clock,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             serial_data_out_oe,
	input  wire logic        eight_sector,
	input  wire logic        high_density,
	output logic             mem_rd_req,
	output logic      [23:0] mem_rd_addr,
	input  wire logic [7:0]  mem_rd_data,
	output logic             op_start,
	output sfci_op_e         op_kind,
	output logic      [23:0] op_addr,
	output logic      [8:0]  op_count,
	input  wire logic        op_done,
	input  wire logic [7:0]  buf_rd_addr,
	output logic      [7:0]  buf_rd_data,
	output logic             write_in_progress,
	output logic             write_enable_latch,
	output logic      [2:0]  protect_level
);
	// ==========================================================
	// protection decode
	function automatic logic sfci_protected(input logic [2:0]  bp,
		input logic eight, input logic [23:0] a);
		logic [2:0] s;
		logic       p;
		s = eight ? a[`SFCI_SEC8_LSB +: 3] : {1'b0, a[`SFCI_SEC4_LSB +: 2]};
		p = 1'b1;
		if (eight) begin
			case (bp)
				3'h0: p = 1'b0;
				3'h1: p = (s == 3'h7);
				3'h2: p = (s >= 3'h6);
				3'h3: p = (s >= 3'h4);
				default: p = 1'b1;
			endcase
		end else begin
			case (bp[1:0])
				2'h0: p = 1'b0;
				2'h1: p = (s == 3'h3);
				2'h2: p = (s >= 3'h2);
				default: p = 1'b1;
			endcase
		end
		return p;
	endfunction : sfci_protected

	// ==========================================================
	// pin synchronisers
	logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_s1  <= 1'b1;
			cs_s2  <= 1'b1;
			cs_s3  <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sdi_s1 <= 1'b0;
			sdi_s2 <= 1'b0;
		end else begin
			cs_s1  <= chip_select_n;
			cs_s2  <= cs_s1;
			cs_s3  <= cs_s2;
			sck_s1 <= serial_clock;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sdi_s1 <= serial_data_in;
			sdi_s2 <= sdi_s1;
		end
	end

	logic sck_rise, sck_fall, cs_rise;
	assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_s3 & ~cs_s2;
	assign cs_rise  = cs_s2 & ~cs_s3;

	// ==========================================================
	// framing
	sfci_state_e state_reg, op_next;
	logic [7:0]  opcode_reg;
	logic [1:0]  left_reg, op_left;
	logic [2:0]  bit_cnt_reg;
	logic [3:0]  byte_cnt_reg;
	logic [8:0]  data_cnt_reg;
	logic [7:0]  page_idx_reg;
	logic [6:0]  in_shift_reg;
	logic [7:0]  ws_byte_reg;
	logic [23:0] addr_reg;
	logic [7:0]  byte_val;
	logic        byte_done;

	assign byte_val  = {in_shift_reg, sdi_s2};
	assign byte_done = sck_rise & (bit_cnt_reg == `SFCI_LAST_BIT);

	always_comb begin
		op_left = `SFCI_ADDR_LEFT;
		case (byte_val)
			`SFCI_OP_WREN, `SFCI_OP_WRDI: op_next = ST_DATA_IN;
			`SFCI_OP_RDSR: op_next = ST_DATA_OUT;
			`SFCI_OP_READ, `SFCI_OP_FAST: op_next = ST_ADDR;
			`SFCI_OP_PROG, `SFCI_OP_SECT: op_next = ST_ADDR;
			`SFCI_OP_WSTAT, `SFCI_OP_BULK: op_next = ST_DATA_IN;
			`SFCI_OP_SID: begin
				op_next = high_density ? ST_IGNORE : ST_DUMMY;
				op_left = `SFCI_SID_LEFT;
			end
			`SFCI_OP_RDID: begin
				op_next = high_density ? ST_DUMMY : ST_IGNORE;
				op_left = `SFCI_RDID_LEFT;
			end
			default: op_next = ST_IGNORE;
		endcase
		// anything touching the array is refused while the cycle runs
		if (write_in_progress && (byte_val == `SFCI_OP_READ
			|| byte_val == `SFCI_OP_FAST || byte_val == `SFCI_OP_PROG
			|| byte_val == `SFCI_OP_SECT || byte_val == `SFCI_OP_BULK
			|| byte_val == `SFCI_OP_WSTAT)) begin
			op_next = ST_IGNORE;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg  <= ST_OPCODE;
			opcode_reg <= 8'h00;
			left_reg   <= 2'h0;
		end else if (cs_s2) begin
			state_reg <= ST_OPCODE;
			left_reg  <= 2'h0;
		end else if (byte_done) begin
			case (state_reg)
				ST_OPCODE: begin
					opcode_reg <= byte_val;
					state_reg  <= op_next;
					left_reg   <= op_left;
				end
				ST_ADDR: begin
					left_reg <= left_reg - 2'h1;
					if (left_reg == 2'h0) begin
						case (opcode_reg)
							`SFCI_OP_READ: state_reg <= ST_DATA_OUT;
							`SFCI_OP_FAST: state_reg <= ST_DUMMY;
							default: state_reg <= ST_DATA_IN;
						endcase
						left_reg <= 2'h0;
					end
				end
				ST_DUMMY: begin
					left_reg <= left_reg - 2'h1;
					if (left_reg == 2'h0) begin
						state_reg <= ST_DATA_OUT;
					end
				end
				default: state_reg <= state_reg;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 4'h0;
			data_cnt_reg <= 9'h000;
			page_idx_reg <= 8'h00;
			in_shift_reg <= 7'h00;
			ws_byte_reg  <= 8'h00;
			addr_reg     <= 24'h00_0000;
		end else if (cs_s2) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 4'h0;
			data_cnt_reg <= 9'h000;
			page_idx_reg <= 8'h00;
		end else if (sck_rise) begin
			bit_cnt_reg  <= bit_cnt_reg + 3'h1;
			in_shift_reg <= byte_val[6:0];
			if (byte_done) begin
				if (byte_cnt_reg != `SFCI_BYTE_MAX) begin
					byte_cnt_reg <= byte_cnt_reg + 4'h1;
				end
				if (state_reg == ST_ADDR) begin
					addr_reg <= {addr_reg[15:0], byte_val};
				end
				if (state_reg == ST_DATA_IN) begin
					if (data_cnt_reg == 9'h000) begin
						ws_byte_reg <= byte_val;
					end
					// byte count saturates, the page index must keep wrapping
					page_idx_reg <= page_idx_reg + 8'h01;
					if (data_cnt_reg != `SFCI_PAGE_BYTES) begin
						data_cnt_reg <= data_cnt_reg + 9'h001;
					end
				end
			end
		end
	end

	// ==========================================================
	// page buffer: index wraps, so the last 256 bytes survive
	logic       buf_wr;
	logic [7:0] buf_addr;
	assign buf_addr = addr_reg[7:0] + page_idx_reg;
	assign buf_wr = byte_done & (state_reg == ST_DATA_IN)
		& (opcode_reg == `SFCI_OP_PROG);

	sfci_page_buf u_buf (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.wr_en   (buf_wr),
		.wr_addr (buf_addr),
		.wr_data (byte_val),
		.rd_addr (buf_rd_addr),
		.rd_data (buf_rd_data)
	);

	// ==========================================================
	// read data path
	logic [2:0] out_bit_reg;
	logic [6:0] out_shift_reg;
	logic [7:0] out_src;
	logic       load_out, is_read, enter_read;

	assign is_read  = (opcode_reg == `SFCI_OP_READ)
		| (opcode_reg == `SFCI_OP_FAST);
	assign load_out = sck_fall & (state_reg == ST_DATA_OUT)
		& (out_bit_reg == 3'h0);
	assign enter_read = byte_done & (left_reg == 2'h0)
		& (((state_reg == ST_ADDR) & (opcode_reg == `SFCI_OP_READ))
		| ((state_reg == ST_DUMMY) & (opcode_reg == `SFCI_OP_FAST)));

	always_comb begin
		case (opcode_reg)
			`SFCI_OP_RDSR: out_src = {3'h0, protect_level,
				write_enable_latch, write_in_progress};
			`SFCI_OP_SID:  out_src = SILICON_ID;
			`SFCI_OP_RDID: out_src = DEVICE_ID;
			default:       out_src = mem_rd_data;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mem_rd_req  <= 1'b0;
			mem_rd_addr <= 24'h00_0000;
		end else if (enter_read) begin
			mem_rd_req  <= 1'b1;
			mem_rd_addr <= (opcode_reg == `SFCI_OP_READ)
				? {addr_reg[15:0], byte_val} : addr_reg;
		end else if (load_out && is_read) begin
			// prefetch the next byte well before its first bit is due
			mem_rd_req  <= 1'b1;
			mem_rd_addr <= mem_rd_addr + 24'h00_0001;
		end else begin
			mem_rd_req <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			out_bit_reg        <= 3'h0;
			out_shift_reg      <= 7'h00;
			serial_data_out    <= 1'b0;
			serial_data_out_oe <= 1'b0;
		end else if (cs_s2) begin
			out_bit_reg        <= 3'h0;
			serial_data_out    <= 1'b0;
			serial_data_out_oe <= 1'b0;
		end else if (sck_fall && state_reg == ST_DATA_OUT) begin
			out_bit_reg        <= out_bit_reg + 3'h1;
			serial_data_out_oe <= 1'b1;
			if (load_out) begin
				serial_data_out <= out_src[7];
				out_shift_reg   <= out_src[6:0];
			end else begin
				serial_data_out <= out_shift_reg[6];
				out_shift_reg   <= {out_shift_reg[5:0], 1'b0};
			end
		end
	end

	// ==========================================================
	// execution at select rise
	logic frame_ok, do_wren, do_wrdi, do_start, prot;
	sfci_op_e kind;

	assign prot     = sfci_protected(protect_level, eight_sector, addr_reg);
	assign frame_ok = cs_rise & (state_reg == ST_DATA_IN)
		& (bit_cnt_reg == 3'h0);
	assign do_wren  = frame_ok & (opcode_reg == `SFCI_OP_WREN)
		& (byte_cnt_reg == `SFCI_OPC_BYTES);
	assign do_wrdi  = frame_ok & (opcode_reg == `SFCI_OP_WRDI)
		& (byte_cnt_reg == `SFCI_OPC_BYTES);

	always_comb begin
		kind     = OP_PROG;
		do_start = 1'b0;
		case (opcode_reg)
			`SFCI_OP_WSTAT: begin
				kind     = OP_WSTAT;
				do_start = byte_cnt_reg == `SFCI_WSTAT_BYTES;
			end
			`SFCI_OP_PROG: begin
				kind     = OP_PROG;
				do_start = (data_cnt_reg != 9'h000) & ~prot;
			end
			`SFCI_OP_SECT: begin
				kind     = OP_SECT;
				do_start = (byte_cnt_reg == `SFCI_SECT_BYTES) & ~prot;
			end
			`SFCI_OP_BULK: begin
				kind     = OP_BULK;
				do_start = (byte_cnt_reg == `SFCI_OPC_BYTES)
					& (protect_level == 3'h0);
			end
			default: do_start = 1'b0;
		endcase
		do_start = do_start & frame_ok & write_enable_latch;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			op_start <= 1'b0;
			op_kind  <= OP_PROG;
			op_addr  <= 24'h00_0000;
			op_count <= 9'h000;
		end else begin
			op_start <= do_start;
			if (do_start) begin
				op_kind  <= kind;
				op_addr  <= addr_reg;
				op_count <= data_cnt_reg;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			write_in_progress <= 1'b0;
		end else if (do_start) begin
			write_in_progress <= 1'b1;
		end else if (op_done) begin
			write_in_progress <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			write_enable_latch <= 1'b0;
		end else if (do_wren) begin
			write_enable_latch <= 1'b1;
		end else if (do_wrdi || (op_done && write_in_progress)) begin
			write_enable_latch <= 1'b0;
		end
	end

	// protect bits only; other status bits are not touched
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			protect_level <= `SFCI_BP_RESET;
		end else if (op_done && write_in_progress && op_kind == OP_WSTAT) begin
			protect_level <= {ws_byte_reg[`SFCI_BP_LSB + 2] & eight_sector,
				ws_byte_reg[`SFCI_BP_LSB +: 2]};
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_wren_frame;
		do_wren;
	endsequence

	chk_wren_sets: assert property (s_wren_frame |=> write_enable_latch)
		else $error("write enable did not set latch");
	chk_wrdi_clears: assert property (do_wrdi |=> !write_enable_latch)
		else $error("write disable did not clear latch");
	chk_done_clears: assert property (op_done && write_in_progress && !do_wren
		|=> !write_enable_latch && !write_in_progress)
		else $error("completion left latch or busy set");
	chk_start_needs_wel: assert property (op_start |-> $past(write_enable_latch))
		else $error("operation started without latch");
	chk_start_busy: assert property (op_start |-> write_in_progress)
		else $error("busy flag not set with start");
	chk_bulk_unprot: assert property (op_start && op_kind == OP_BULK
		|-> $past(protect_level) == 3'h0)
		else $error("bulk erase while protected");
	chk_whole_bytes: assert property (op_start |-> $past(bit_cnt_reg) == 3'h0)
		else $error("start on partial byte");
	chk_busy_refuse: assert property (byte_done && state_reg == ST_OPCODE
		&& write_in_progress && byte_val == `SFCI_OP_READ
		|=> state_reg == ST_IGNORE)
		else $error("read accepted while busy");
	chk_sdo_fall: assert property ($changed(serial_data_out)
		|-> $past(sck_fall || cs_s2))
		else $error("data out moved off a falling edge");
	chk_page_count: assert property (op_start && op_kind == OP_PROG
		|-> op_count != 9'h000 && op_count <= `SFCI_PAGE_BYTES)
		else $error("program byte count out of range");
endmodule : sfci_top

// ===== sfci_host_model.sv
`timescale 1ns/100ps
module sfci_host_model (
	input  wire logic mclk,
	input  wire logic serial_data_out,
	input  wire logic serial_data_out_oe,
	output logic      chip_select_n,
	output logic      serial_clock,
	output logic      serial_data_in
);
	logic [7:0] tx_buf [0:299];
	logic       any_oe;
	logic       last_sdo;

	initial begin
		chip_select_n = 1'b1;
		serial_clock = 1'b0;
		serial_data_in = 1'b0;
		any_oe = 1'b0;
		last_sdo = 1'b0;
	end

	// ==========================================================
	// one frame: ncmd command bits, then nrd read-back bits
	// clock parks low between frames, four mclk per phase
	task automatic xfer(input int ncmd, input int nrd, output logic [63:0] rx);
		int i;
		rx = '0;
		any_oe = 1'b0;
		@(negedge mclk);
		chip_select_n = 1'b0;
		repeat (4) @(negedge mclk);
		for (i = 0; i < ncmd + nrd; i++) begin
			if (i < ncmd)
				serial_data_in = tx_buf[i / 8][7 - i % 8];
			else
				serial_data_in = ~serial_data_in;
			repeat (4) @(negedge mclk);
			serial_clock = 1'b1;
			// released line must not look like valid data
			last_sdo = serial_data_out_oe ? serial_data_out : ~last_sdo;
			any_oe = any_oe | serial_data_out_oe;
			rx = {rx[62:0], last_sdo};
			repeat (4) @(negedge mclk);
			serial_clock = 1'b0;
		end
		repeat (4) @(negedge mclk);
		chip_select_n = 1'b1;
		serial_data_in = ~serial_data_in;
		repeat (8) @(negedge mclk);
	endtask : xfer
endmodule : sfci_host_model

// ===== sfci_top_test.sv
`timescale 1ns/100ps
`include "sfci_defs.svh"
module sfci_top_test import sfci_pkg::*;;
	// identity values are arbitrary
	localparam logic [7:0] SID = 8'h3C;
	localparam logic [7:0] DID = 8'hC3;
	typedef struct {
		sfci_op_e    kind;
		logic [23:0] addr;
		logic [8:0]  cnt;
	} sfci_note_s;
	logic        mclk, sys_rst, chip_select_n, serial_clock, serial_data_in;
	logic        serial_data_out, serial_data_out_oe, eight_sector, high_density;
	logic        mem_rd_req, op_start, op_done, write_in_progress;
	logic        write_enable_latch;
	logic [23:0] mem_rd_addr, op_addr, a;
	logic [7:0]  mem_rd_data, buf_rd_addr, buf_rd_data;
	logic [8:0]  op_count;
	logic [2:0]  protect_level;
	sfci_op_e    op_kind;
	logic [31:0] seed;
	logic [63:0] rx;
	logic [7:0]  dat [0:299];
	sfci_note_s  exp_q [$];
	sfci_note_s  nt;
	int          error_cnt, n_tests, b, s, e;

	sfci_top #(.SILICON_ID(SID), .DEVICE_ID(DID)) uut (.mclk, .sys_rst,
		.chip_select_n, .serial_clock, .serial_data_in, .serial_data_out,
		.serial_data_out_oe, .eight_sector, .high_density, .mem_rd_req,
		.mem_rd_addr, .mem_rd_data, .op_start, .op_kind, .op_addr, .op_count,
		.op_done, .buf_rd_addr, .buf_rd_data, .write_in_progress,
		.write_enable_latch, .protect_level);
	sfci_host_model host (.mclk, .serial_data_out, .serial_data_out_oe,
		.chip_select_n, .serial_clock, .serial_data_in);

	// ==========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [7:0] fdat(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16];
	endfunction : fdat
	function automatic logic [7:0] stat(input logic [2:0] bp, input logic wel);
		return {3'h0, bp, wel, 1'b0};
	endfunction : stat
	function automatic logic prot(input logic ei, input logic [2:0] bp, input int si);
		if (ei)
			return bp[2] || (bp == 3'h3 && si >= 4) || (bp == 3'h2 && si >= 6) || (bp == 3'h1 && si == 7);
		return bp == 3'h3 || (bp == 3'h2 && si >= 2) || (bp == 3'h1 && si == 3);
	endfunction : prot
	task automatic chk(input logic [63:0] got, input logic [63:0] expv);
		n_tests++;
		if (got !== expv) begin
			error_cnt++;
			$display("ERROR t=%0t got %0h expected %0h", $time, got, expv);
		end
	endtask : chk
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	task automatic cmd(input logic [7:0] op, input int nadr, input logic [23:0] ad,
		input int ndat, input int d0, input int xb, input int nrd);
		int j;
		host.tx_buf[0] = op;
		host.tx_buf[1] = ad[23:16];
		host.tx_buf[2] = ad[15:8];
		host.tx_buf[3] = ad[7:0];
		for (j = 0; j <= ndat; j++) begin
			seed = lfsr(seed);
			dat[j] = (j == 0 && d0 >= 0) ? d0[7:0] : seed[7:0];
			host.tx_buf[1 + nadr + j] = dat[j];
		end
		host.xfer(8 * (1 + nadr + ndat) + xb, nrd, rx);
	endtask : cmd
	task automatic note(input sfci_op_e k, input logic [23:0] ad, input logic [8:0] c);
		exp_q.push_back('{k, ad, c});
	endtask : note
	task automatic settle();
		repeat (4) @(negedge mclk);
		chk(exp_q.size(), 0);
		exp_q.delete();
	endtask : settle
	task automatic done_op();
		chk(write_in_progress, 1'b1);
		@(negedge mclk);
		op_done = 1'b1;
		@(negedge mclk);
		op_done = 1'b0;
		repeat (4) @(negedge mclk);
		chk(write_in_progress, 1'b0);
		chk(write_enable_latch, 1'b0);
	endtask : done_op
	task automatic rdsr(input logic [7:0] sv, input logic wip);
		cmd(`SFCI_OP_RDSR, 0, 0, 0, -1, 0, 16);
		chk(rx[15:0], {2{sv | {7'h0, wip}}});
	endtask : rdsr
	task automatic wren();
		cmd(`SFCI_OP_WREN, 0, 0, 0, -1, 0, 0);
	endtask : wren
	task automatic chkbuf(input logic [7:0] i, input logic [7:0] d);
		buf_rd_addr = i;
		repeat (2) @(negedge mclk);
		chk(buf_rd_data, d);
	endtask : chkbuf
	task automatic set_bp(input logic [2:0] bp);
		wren();
		note(OP_WSTAT, 0, 0);
		// other status bits offered as ones, they must not stick
		cmd(`SFCI_OP_WSTAT, 0, 0, 1, {3'h7, bp, 2'h3}, 0, 0);
		settle();
		done_op();
		chk(protect_level, bp);
		rdsr(stat(bp, 1'b0), 1'b0);
	endtask : set_bp
	task automatic rst();
		sys_rst = 1'b1;
		repeat (16) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
	endtask : rst

	// ==========================================================
	// clock, array side, monitor, watchdog
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// array answers only what was requested, and holds it until the next one
	always @(negedge mclk)
		if (mem_rd_req === 1'b1)
			mem_rd_data <= fdat(mem_rd_addr);
	always @(negedge mclk) begin
		if (op_start === 1'b1) begin
			if (exp_q.size() == 0)
				chk(1, 0);
			else begin
				nt = exp_q.pop_front();
				chk(op_kind, nt.kind);
				if (nt.kind == OP_PROG || nt.kind == OP_SECT)
					chk(op_addr, nt.addr);
				if (nt.kind == OP_PROG)
					chk(op_count, nt.cnt);
			end
		end
	end
	initial begin
		repeat (95000) @(posedge mclk);
		error_cnt++;
		end_sim();
	end

	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h29ff_8404;
		sys_rst = 1'b1;
		eight_sector = 1'b0;
		high_density = 1'b0;
		op_done = 1'b0;
		buf_rd_addr = 8'h00;
		rst();
		chk(write_enable_latch, 1'b0);
		rdsr(stat(3'h0, 1'b0), 1'b0);
		wren();
		rdsr(stat(3'h0, 1'b1), 1'b0);
		cmd(`SFCI_OP_PROG, 3, 24'h00_0010, 1, -1, 3, 0);
		settle();
		cmd(`SFCI_OP_WRDI, 0, 0, 0, -1, 0, 0);
		rdsr(stat(3'h0, 1'b0), 1'b0);
		cmd(`SFCI_OP_PROG, 3, 24'h00_0010, 1, -1, 0, 0);
		settle();
		$display("test latch done");
		seed = lfsr(seed);
		a = seed[23:0];
		wren();
		note(OP_PROG, a, 9'h003);
		cmd(`SFCI_OP_PROG, 3, a, 3, -1, 0, 0);
		settle();
		// later commands reuse the data array, so look at the page now
		for (b = 0; b < 3; b++)
			chkbuf(8'(a[7:0] + b), dat[b]);
		rdsr(stat(3'h0, 1'b1), 1'b1);
		cmd(`SFCI_OP_WSTAT, 0, 0, 1, 8'h1C, 0, 0);
		settle();
		cmd(`SFCI_OP_READ, 3, a, 0, -1, 0, 8);
		chk(host.any_oe, 1'b0);
		done_op();
		rdsr(stat(3'h0, 1'b0), 1'b0);
		wren();
		note(OP_PROG, 24'h00_0100, 9'h100);
		cmd(`SFCI_OP_PROG, 3, 24'h00_0100, 258, -1, 0, 0);
		settle();
		done_op();
		for (b = 0; b < 256; b++)
			chkbuf(8'(b), dat[b < 2 ? b + 256 : b]);
		$display("test program done");
		seed = lfsr(seed);
		a = seed[23:0];
		cmd(`SFCI_OP_READ, 3, a, 0, -1, 0, 16);
		chk(rx[15:0], {fdat(a), fdat(a + 24'h1)});
		cmd(`SFCI_OP_FAST, 3, a, 1, -1, 0, 16);
		chk(rx[15:0], {fdat(a), fdat(a + 24'h1)});
		cmd(`SFCI_OP_READ, 3, a, 0, -1, 0, 3);
		rdsr(stat(3'h0, 1'b0), 1'b0);
		for (b = 0; b < 2; b++) begin
			high_density = b[0];
			rst();
			cmd(`SFCI_OP_SID, 0, 0, 3, -1, 0, 16);
			if (b == 0)
				chk(rx[15:0], {2{SID}});
			else
				chk(host.any_oe, 1'b0);
			cmd(`SFCI_OP_RDID, 0, 0, 2, -1, 0, 16);
			if (b == 1)
				chk(rx[15:0], {2{DID}});
			else
				chk(host.any_oe, 1'b0);
		end
		cmd(8'hFF, 0, 0, 0, -1, 0, 16);
		chk(host.any_oe, 1'b0);
		rdsr(stat(3'h0, 1'b0), 1'b0);
		$display("test read done");
		for (e = 0; e < 2; e++) begin
			eight_sector = e[0];
			rst();
			for (b = 0; b < (e ? 8 : 4); b++) begin
				set_bp(b[2:0]);
				for (s = 0; s < (e ? 8 : 4); s++) begin
					a = 24'(s) << (e ? 16 : 15);
					wren();
					if (!prot(e[0], b[2:0], s))
						note(OP_SECT, a, 9'h000);
					cmd(`SFCI_OP_SECT, 3, a, 0, -1, 0, 0);
					settle();
					if (!prot(e[0], b[2:0], s))
						done_op();
				end
				wren();
				if (b == 0)
					note(OP_BULK, 0, 0);
				cmd(`SFCI_OP_BULK, 0, 0, 0, -1, 0, 0);
				settle();
				if (b == 0)
					done_op();
			end
		end
		wren();
		cmd(`SFCI_OP_PROG, 3, 24'h00_0000, 1, -1, 0, 0);
		settle();
		cmd(`SFCI_OP_WSTAT, 0, 0, 2, 0, 0, 0);
		settle();
		chk(protect_level, 3'h7);
		$display("test protect done");
		end_sim();
	end
endmodule : sfci_top_test
